//--- core/sdio_pkg.sv
package sdio_pkg;

    // Register offsets of the plain register port.
    localparam logic [3:0] SDIO_CTRL_ADDR   = 4'h0;
    localparam logic [3:0] SDIO_STAT_ADDR   = 4'h1;
    localparam logic [3:0] SDIO_IRQ_ADDR    = 4'h2;
    localparam logic [3:0] SDIO_MASK_ADDR   = 4'h3;
    localparam logic [3:0] SDIO_MON0_ADDR   = 4'h4;
    localparam logic [3:0] SDIO_MON1_ADDR   = 4'h5;
    localparam logic [3:0] SDIO_FAULT_ADDR  = 4'h6;

    // Control register fields.
    localparam int CTRL_INH_POL    = 0;
    localparam int CTRL_RUN_POL    = 1;
    localparam int CTRL_ESTOP_POL  = 2;
    localparam int CTRL_RST_POL    = 3;
    localparam int CTRL_FAULT_POL  = 4;
    localparam int CTRL_HALL_EN    = 5;
    localparam int CTRL_NVM_BUSY   = 6;
    localparam int CTRL_SEL0_LSB   = 8;
    localparam int CTRL_SEL1_LSB   = 10;
    localparam int CTRL_W          = 12;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h020;

    // Interrupt event bits.
    localparam int IRQ_W       = 4;
    localparam int EV_INHIBIT  = 0;
    localparam int EV_ESTOP    = 1;
    localparam int EV_FAULT    = 2;
    localparam int EV_AT_SPEED = 3;

    localparam int DATA_W = 16;
    localparam int MON_W  = 12;

    // Servo update period.
    localparam int SERVO_PERIOD_NS = 50000;
    localparam int CLK_PERIOD_NS   = 10;
    localparam int SERVO_CYCLES    = SERVO_PERIOD_NS / CLK_PERIOD_NS;

    // Seven-segment patterns, bit order g f e d c b a.
    localparam logic [6:0] SEG_ZERO  = 7'h3f;
    localparam logic [6:0] SEG_EIGHT = 7'h7f;
    localparam logic [6:0] SEG_C     = 7'h39;
    localparam logic [6:0] SEG_F     = 7'h71;

    typedef enum logic [1:0]
    {
        SDIO_ST_RESET = 2'b00,
        SDIO_ST_RUN   = 2'b01,
        SDIO_ST_CLAMP = 2'b10,
        SDIO_ST_FAULT = 2'b11
    } sdio_state_type;

    // Outer segment for each of the six hall steps.
    function automatic logic [6:0] sdio_hall_seg(input logic [2:0] step);
        sdio_hall_seg = 7'h01 << step;
    endfunction

endpackage

//--- core/sdio_sync.sv
`timescale 1ns/10ps

module sdio_sync import sdio_pkg::*;
#(
    parameter int W = 4
)
(
    // Clock and reset.
    input  wire logic         clk_i,
    input  wire logic         reset_n_i,
    // Raw and synchronised levels.
    input  wire logic [W-1:0] async_i,
    input  wire logic [W-1:0] pol_i,
    output logic      [W-1:0] active_o
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] active_q;
    logic [W-1:0] active_d;

    // The first stage feeds only the second stage.
    always_comb
    begin
        active_d = ~(sync_q ^ pol_i);
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            // Idle pins sit high under the default active-low setting, so the
            // stages start there; zeros would fake active inputs after reset.
            meta_q   <= '1;
            sync_q   <= '1;
            active_q <= '0;
        end
        else
        begin
            meta_q   <= async_i;
            sync_q   <= meta_q;
            active_q <= active_d;
        end
    end

    assign active_o = active_q;

    sync_delay_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        ##3 (active_q == ~($past(async_i, 3) ^ $past(pol_i, 1))))
        else $error("synchronised input does not follow pin after three cycles");

endmodule

//--- core/sdio_mon.sv
`timescale 1ns/10ps

module sdio_mon import sdio_pkg::*;
#(
    parameter int PERIOD = SERVO_CYCLES
)
(
    // Clock and reset.
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    // Control.
    input  wire logic             hold_i,
    input  wire logic [MON_W-1:0] src0_i,
    input  wire logic [MON_W-1:0] src1_i,
    // Monitor codes.
    output logic      [MON_W-1:0] mon0_o,
    output logic      [MON_W-1:0] mon1_o,
    output logic                  tick_o
);

    logic [$clog2(PERIOD)-1:0] cnt_q;
    logic [$clog2(PERIOD)-1:0] cnt_d;
    logic                      tick_q;
    logic                      tick_d;
    logic [MON_W-1:0]          mon0_q;
    logic [MON_W-1:0]          mon0_d;
    logic [MON_W-1:0]          mon1_q;
    logic [MON_W-1:0]          mon1_d;

    always_comb
    begin
        tick_d = (cnt_q == ($clog2(PERIOD))'(PERIOD - 1));
        cnt_d  = tick_d ? '0 : cnt_q + 1'b1;
        mon0_d = mon0_q;
        mon1_d = mon1_q;
        // Outputs freeze while parameters move to or from storage.
        if (tick_d && !hold_i)
        begin
            mon0_d = src0_i;
            mon1_d = src1_i;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
            mon0_q <= '0;
            mon1_q <= '0;
        end
        else
        begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
            mon0_q <= mon0_d;
            mon1_q <= mon1_d;
        end
    end

    assign mon0_o = mon0_q;
    assign mon1_o = mon1_q;
    assign tick_o = tick_q;

    mon_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        hold_i |=> $stable(mon0_q) && $stable(mon1_q))
        else $error("monitor output changed during storage access");

    mon_update_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !tick_d |=> $stable(mon0_q))
        else $error("monitor output changed outside update tick");

endmodule

//--- core/sdio_top.sv
// Overview of operation
// - Hall mode lights one outer segment
// - Six segments step once per commutation cycle
// - Hall unused shows zero pattern
// - Clamp or fault replaces hall segment
// - Inhibit frees motor and shows C
// - Run/hold ignores command, stage stays enabled
// - Emergency stop disables stage, shows C
// - Input polarities selectable by configuration
// - Reset polarity configurable, shows 8
// - Reset clears latched faults and state
// - Fault output with configurable polarity
// - Relay closed only while at speed
// - Two 12-bit monitor outputs
// - Monitors update once per servo period
// - Monitors suspended during storage access
//
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps

module sdio_top import sdio_pkg::*;
#(
    parameter int SERVO_PERIOD = SERVO_CYCLES
)
(
    // Clock and reset.
    input  wire logic              clk_i,
    input  wire logic              reset_n_i,
    // Register port.
    input  wire logic [3:0]        addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [DATA_W-1:0] rdata_o,
    // Discrete inputs from the controller.
    input  wire logic              inhibit_i,
    input  wire logic              run_hold_i,
    input  wire logic              estop_i,
    input  wire logic              ext_reset_i,
    // Internal status from the drive core.
    input  wire logic [2:0]        hall_i,
    input  wire logic              fault_event_i,
    input  wire logic              at_speed_i,
    input  wire logic [MON_W-1:0]  sig_a_i,
    input  wire logic [MON_W-1:0]  sig_b_i,
    input  wire logic [MON_W-1:0]  sig_c_i,
    input  wire logic [MON_W-1:0]  sig_d_i,
    // Discrete and display outputs.
    output logic [6:0]             seg_o,
    output logic                   stage_en_o,
    output logic                   cmd_en_o,
    output logic                   estop_run_o,
    output logic                   core_reset_o,
    output logic                   fault_o,
    output logic                   relay_o,
    output logic [MON_W-1:0]       mon0_o,
    output logic [MON_W-1:0]       mon1_o,
    output logic                   irq_o
);

    ////////////////////////////////////////////////////////////////////////////

    logic [CTRL_W-1:0] ctrl_q;
    logic [CTRL_W-1:0] ctrl_d;
    logic [IRQ_W-1:0]  irq_q;
    logic [IRQ_W-1:0]  irq_d;
    logic [IRQ_W-1:0]  mask_q;
    logic [IRQ_W-1:0]  mask_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic              fault_lat_q;
    logic              fault_lat_d;
    logic [2:0]        step_q;
    logic [2:0]        step_d;
    logic [2:0]        hall_q;
    logic [6:0]        seg_q;
    logic [6:0]        seg_d;
    sdio_state_type    state_q;
    sdio_state_type    state_d;
    logic              stage_en_q;
    logic              cmd_en_q;
    logic              estop_run_q;
    logic              core_reset_q;
    logic              fault_q;
    logic              relay_q;
    logic              irq_out_q;
    logic              at_speed_q;
    logic [3:0]        act;
    logic [3:0]        pol;
    logic [IRQ_W-1:0]  events;
    logic              inh_act;
    logic              run_act;
    logic              est_act;
    logic              rst_act;
    logic              mon_tick;
    logic [MON_W-1:0]  src0;
    logic [MON_W-1:0]  src1;

    // Picks one of four internal signals for a monitor channel.
    function automatic logic [MON_W-1:0] pick(input logic [1:0] sel);
        unique case (sel)
            2'b00: pick = sig_a_i;
            2'b01: pick = sig_b_i;
            2'b10: pick = sig_c_i;
            2'b11: pick = sig_d_i;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////

    assign pol = {ctrl_q[CTRL_RST_POL], ctrl_q[CTRL_ESTOP_POL],
                  ctrl_q[CTRL_RUN_POL], ctrl_q[CTRL_INH_POL]};

    sdio_sync #(.W(4)) u_sync
    (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .async_i   ({ext_reset_i, estop_i, run_hold_i, inhibit_i}),
        .pol_i     (pol),
        .active_o  (act)
    );

    assign inh_act = act[0];
    assign run_act = act[1];
    assign est_act = act[2];
    assign rst_act = act[3];
    assign src0    = pick(ctrl_q[CTRL_SEL0_LSB +: 2]);
    assign src1    = pick(ctrl_q[CTRL_SEL1_LSB +: 2]);

    sdio_mon #(.PERIOD(SERVO_PERIOD)) u_mon
    (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .hold_i    (ctrl_q[CTRL_NVM_BUSY]),
        .src0_i    (src0),
        .src1_i    (src1),
        .mon0_o    (mon0_o),
        .mon1_o    (mon1_o),
        .tick_o    (mon_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register port and interrupts.

    // Inhibit and stop are levels, so their status bits keep setting while the
    // input stays active; a read clears them only once the input is released.
    assign events = {at_speed_i & ~at_speed_q, fault_event_i, est_act, inh_act};

    always_comb
    begin
        ctrl_d  = ctrl_q;
        mask_d  = mask_q;
        irq_d   = irq_q;
        rdata_d = '0;
        if (wr_i && addr_i == SDIO_CTRL_ADDR)
        begin
            ctrl_d = wdata_i[CTRL_W-1:0];
        end
        if (wr_i && addr_i == SDIO_MASK_ADDR)
        begin
            mask_d = wdata_i[IRQ_W-1:0];
        end
        if (rd_i)
        begin
            unique case (addr_i)
                SDIO_CTRL_ADDR:  rdata_d = DATA_W'(ctrl_q);
                SDIO_STAT_ADDR:  rdata_d = DATA_W'({state_q, seg_q});
                SDIO_IRQ_ADDR:   rdata_d = DATA_W'(irq_q);
                SDIO_MASK_ADDR:  rdata_d = DATA_W'(mask_q);
                SDIO_MON0_ADDR:  rdata_d = DATA_W'(mon0_o);
                SDIO_MON1_ADDR:  rdata_d = DATA_W'(mon1_o);
                SDIO_FAULT_ADDR: rdata_d = DATA_W'(fault_lat_q);
                default:         rdata_d = '0;
            endcase
            if (addr_i == SDIO_IRQ_ADDR)
            begin
                irq_d = '0;
            end
        end
        // A new event beats the read clear.
        irq_d = irq_d | events;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Drive state, display and discrete outputs.

    always_comb
    begin
        fault_lat_d = fault_lat_q | fault_event_i;
        step_d      = step_q;
        // Hall code changes advance the ring; a full ring is two poles.
        if (hall_i != hall_q)
        begin
            step_d = (step_q == 3'h5) ? 3'h0 : step_q + 3'h1;
        end
        if (rst_act)
        begin
            state_d     = SDIO_ST_RESET;
            fault_lat_d = 1'b0;
            step_d      = 3'h0;
        end
        else if (fault_lat_q)
        begin
            state_d = SDIO_ST_FAULT;
        end
        else if (inh_act || est_act)
        begin
            state_d = SDIO_ST_CLAMP;
        end
        else
        begin
            state_d = SDIO_ST_RUN;
        end
        unique case (state_q)
            SDIO_ST_RESET: seg_d = SEG_EIGHT;
            SDIO_ST_CLAMP: seg_d = SEG_C;
            SDIO_ST_FAULT: seg_d = SEG_F;
            SDIO_ST_RUN:   seg_d = ctrl_q[CTRL_HALL_EN] ? sdio_hall_seg(step_q)
                                                        : SEG_ZERO;
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ctrl_q       <= CTRL_RESET;
            mask_q       <= '0;
            irq_q        <= '0;
            rdata_q      <= '0;
            fault_lat_q  <= 1'b0;
            step_q       <= 3'h0;
            hall_q       <= 3'h0;
            seg_q        <= SEG_EIGHT;
            state_q      <= SDIO_ST_RESET;
            stage_en_q   <= 1'b0;
            cmd_en_q     <= 1'b0;
            estop_run_q  <= 1'b0;
            core_reset_q <= 1'b1;
            fault_q      <= 1'b0;
            relay_q      <= 1'b0;
            irq_out_q    <= 1'b0;
            at_speed_q   <= 1'b0;
        end
        else
        begin
            ctrl_q       <= ctrl_d;
            mask_q       <= mask_d;
            irq_q        <= irq_d;
            rdata_q      <= rdata_d;
            fault_lat_q  <= fault_lat_d;
            step_q       <= step_d;
            hall_q       <= hall_i;
            seg_q        <= seg_d;
            state_q      <= state_d;
            stage_en_q   <= (state_d == SDIO_ST_RUN);
            cmd_en_q     <= (state_d == SDIO_ST_RUN) && !run_act;
            estop_run_q  <= est_act && !rst_act;
            core_reset_q <= rst_act;
            fault_q      <= fault_lat_d ~^ ctrl_q[CTRL_FAULT_POL];
            relay_q      <= at_speed_i;
            irq_out_q    <= |(irq_d & mask_d);
            at_speed_q   <= at_speed_i;
        end
    end

    assign rdata_o      = rdata_q;
    assign seg_o        = seg_q;
    assign stage_en_o   = stage_en_q;
    assign cmd_en_o     = cmd_en_q;
    assign estop_run_o  = estop_run_q;
    assign core_reset_o = core_reset_q;
    assign fault_o      = fault_q;
    assign relay_o      = relay_q;
    assign irq_o        = irq_out_q;

    ////////////////////////////////////////////////////////////////////////////

    sequence reset_seen;
        rst_act;
    endsequence

    sequence eight_shown;
        ##2 (seg_q == SEG_EIGHT);
    endsequence

    reset_eight_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        reset_seen ##1 rst_act |-> eight_shown)
        else $error("reset did not show all segments");

    reset_clear_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        rst_act |=> !fault_lat_q)
        else $error("reset left a latched fault");

    clamp_char_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (inh_act && !rst_act && !fault_lat_q)[*3] |-> seg_q == SEG_C && !stage_en_q)
        else $error("inhibit did not clamp");

    estop_char_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        (est_act && !rst_act && !fault_lat_q)[*3] |-> seg_q == SEG_C && estop_run_q)
        else $error("emergency stop did not clamp");

    hold_cmd_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        run_act |=> !cmd_en_q)
        else $error("command accepted during hold");

    fault_level_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        fault_event_i && !rst_act ##1 !rst_act |=> (fault_o == $past(ctrl_q[CTRL_FAULT_POL], 1)))
        else $error("fault output at wrong level");

    relay_speed_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        relay_o == $past(at_speed_i))
        else $error("relay does not follow at-speed");

    one_seg_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        state_q == SDIO_ST_RUN && ctrl_q[CTRL_HALL_EN] && $stable(ctrl_q) |=> $onehot(seg_q))
        else $error("hall display not one segment");

    zero_seg_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        state_q == SDIO_ST_RUN && !ctrl_q[CTRL_HALL_EN] |=> seg_q == SEG_ZERO)
        else $error("zero pattern missing");

    step_wrap_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        step_q <= 3'h5)
        else $error("hall step beyond six");

    sequence fault_latched;
        fault_lat_q && !rst_act;
    endsequence

    fault_char_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        fault_latched |=> ##1 (seg_q == SEG_F))
        else $error("fault did not show its character");

    // Hold only refuses commands; the stage stays powered so the motor coasts.
    hold_stage_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        run_act && !inh_act && !est_act && !rst_act && !fault_lat_q |=> stage_en_q)
        else $error("hold disabled the power stage");

    // A tick shows the codes picked one cycle before, unless storage access froze them.
    mon_pick_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        mon_tick && !$past(ctrl_q[CTRL_NVM_BUSY])
        |-> mon0_o == $past(src0) && mon1_o == $past(src1))
        else $error("monitor code does not match its selection");

endmodule

//--- tb/sdio_ctrl_model.sv
`timescale 1ns/10ps

module sdio_ctrl_model
(
    // Clock.
    input  wire logic       clk_i,
    // Requested activity, polarity and lag; index 0 inhibit, 1 run/hold, 2 stop, 3 reset.
    input  wire logic [3:0] act_i,
    input  wire logic [3:0] pol_i,
    input  wire logic [3:0] lag_i,
    // Discrete pins towards the amplifier.
    output logic            inhibit_o,
    output logic            run_hold_o,
    output logic            estop_o,
    output logic            ext_reset_o
);
    logic [3:0] pins_q = 4'hf;
    logic [3:0] pins_d;
    logic [3:0] wait_q = 4'h0;
    logic [3:0] wait_d;
    logic [3:0] want;

    // A slow controller keeps the old levels for lag_i cycles before it follows a change.
    always_comb
    begin
        want   = ~(act_i ^ pol_i);
        pins_d = pins_q;
        wait_d = 4'h0;
        if (want != pins_q)
        begin
            if (wait_q >= lag_i)
                pins_d = want;
            else
                wait_d = wait_q + 4'h1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        pins_q <= pins_d;
        wait_q <= wait_d;
    end

    assign {ext_reset_o, estop_o, run_hold_o, inhibit_o} = pins_q;
endmodule

//--- tb/sdio_top_tb.sv
`timescale 1ns/10ps

module sdio_top_tb import sdio_pkg::*;;
    logic              clk_i = 1'b0;
    logic              reset_n_i = 1'b0;
    logic [3:0]        addr_i = 4'h0;
    logic [DATA_W-1:0] wdata_i = '0;
    logic              wr_i = 1'b0;
    logic              rd_i = 1'b0;
    logic [2:0]        hall_i = 3'h0;
    logic              fault_event_i = 1'b0;
    logic              at_speed_i = 1'b0;
    logic [MON_W-1:0]  sig_a_i = '0, sig_b_i = '0, sig_c_i = '0, sig_d_i = '0;
    logic [3:0]        act = 4'h0, pol = 4'h0, lag = 4'h0;
    logic              inhibit_i, run_hold_i, estop_i, ext_reset_i;
    logic [DATA_W-1:0] rdata_o;
    logic [6:0]        seg_o;
    logic              stage_en_o, cmd_en_o, estop_run_o, core_reset_o, fault_o, relay_o, irq_o;
    logic [MON_W-1:0]  mon0_o, mon1_o;
    logic [CTRL_W-1:0] ctrl = CTRL_RESET;
    logic [15:0]       r;
    logic [6:0]        s;
    logic [MON_W-1:0]  e;
    int                errors = 0;
    int                checked = 0;

    // The short servo period keeps the monitor checks brief.
    sdio_top #(.SERVO_PERIOD(8)) i_sdio_top (.clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i,
        .rd_i, .rdata_o, .inhibit_i, .run_hold_i, .estop_i, .ext_reset_i, .hall_i,
        .fault_event_i, .at_speed_i, .sig_a_i, .sig_b_i, .sig_c_i, .sig_d_i, .seg_o,
        .stage_en_o, .cmd_en_o, .estop_run_o, .core_reset_o, .fault_o, .relay_o, .mon0_o,
        .mon1_o, .irq_o);

    sdio_ctrl_model i_sdio_ctrl_model (.clk_i, .act_i(act), .pol_i(pol), .lag_i(lag),
        .inhibit_o(inhibit_i), .run_hold_o(run_hold_i), .estop_o(estop_i),
        .ext_reset_o(ext_reset_i));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        if (errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Outputs are read at an edge, so they show the value of the cycle before it.
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(posedge clk_i);
        d = rdata_o;
    endtask

    task automatic set_ctrl(input logic [CTRL_W-1:0] c);
        ctrl = c;
        wr(SDIO_CTRL_ADDR, 16'(c));
        pol <= c[3:0];
        wait_n(16);
    endtask

    function automatic logic [6:0] next_seg(input logic [6:0] v);
        return (v == 7'h20) ? 7'h01 : v << 1;
    endfunction

    function automatic logic [MON_W-1:0] pick(input logic [1:0] sel);
        return (sel == 2'd0) ? sig_a_i : (sel == 2'd1) ? sig_b_i : (sel == 2'd2) ? sig_c_i : sig_d_i;
    endfunction

    function automatic logic exp_fault(input logic f, input logic p);
        return f ? p : ~p;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        forever #5 clk_i = ~clk_i;
    end

    initial
    begin
        wait_n(20000);
        errors++;
        summarize();
    end

    initial
    begin
        void'($urandom(75540));
        lag = 4'($urandom_range(3));
        wait_n(6);
        reset_n_i <= 1'b1;
        wait_n(16);
        rd(SDIO_CTRL_ADDR, r);
        chk(r, 16'(CTRL_RESET));
        rd(4'(7 + $urandom_range(8)), r);
        chk(r, 16'h0);
        wr(SDIO_FAULT_ADDR, 16'hffff);
        rd(SDIO_FAULT_ADDR, r);
        chk(r, 16'h0);
        chk(16'({stage_en_o, cmd_en_o, fault_o}), 16'h7);
        chk(16'($countones(seg_o[5:0]) == 1 && !seg_o[6]), 16'h1);
        s = seg_o;
        for (int k = 0; k < 7; k++)
        begin
            hall_i <= hall_i + 3'h1;
            wait_n(8 + $urandom_range(4));
            s = next_seg(s);
            chk(16'(seg_o), 16'(s));
        end
        rd(SDIO_STAT_ADDR, r);
        chk(r, {7'h0, 2'b01, s});
        set_ctrl(CTRL_RESET & ~12'h020);
        chk(16'(seg_o), 16'(SEG_ZERO));
        for (int k = 0; k < 3; k++)
        begin
            set_ctrl((CTRL_RESET & ~12'h00f) | 12'($urandom_range(15)));
            act[k] <= 1'b1;
            wait_n(16);
            if (k != 1)
                chk(16'({seg_o, stage_en_o}), 16'({SEG_C, 1'b0}));
            else
                chk(16'({cmd_en_o, stage_en_o}), 16'h1);
            if (k == 2)
                chk(16'(estop_run_o), 16'h1);
            if (k == 0)
                rd(SDIO_STAT_ADDR, r);
            if (k == 0)
                chk(r, 16'h139);
            act[k] <= 1'b0;
            wait_n(16);
            chk(16'({cmd_en_o, stage_en_o}), 16'h3);
        end
        rd(SDIO_IRQ_ADDR, r);
        wr(SDIO_MASK_ADDR, 16'h0);
        act[0] <= 1'b1;
        wait_n(16);
        act[0] <= 1'b0;
        wait_n(16);
        chk(16'(irq_o), 16'h0);
        wr(SDIO_MASK_ADDR, 16'h1);
        wait_n(3);
        chk(16'(irq_o), 16'h1);
        rd(SDIO_IRQ_ADDR, r);
        chk(r & 16'h1, 16'h1);
        wait_n(3);
        chk(16'(irq_o), 16'h0);
        fault_event_i <= 1'b1;
        wait_n(1);
        fault_event_i <= 1'b0;
        wait_n(8);
        chk(16'({seg_o, fault_o}), 16'({SEG_F, exp_fault(1'b1, ctrl[CTRL_FAULT_POL])}));
        rd(SDIO_IRQ_ADDR, r);
        chk(r, 16'h4);
        set_ctrl(ctrl ^ 12'h010);
        chk(16'(fault_o), 16'(exp_fault(1'b1, ctrl[CTRL_FAULT_POL])));
        act[3] <= 1'b1;
        wait_n(16);
        chk(16'({seg_o, core_reset_o}), 16'({SEG_EIGHT, 1'b1}));
        act[3] <= 1'b0;
        wait_n(16);
        chk(16'({seg_o == SEG_F, fault_o}), 16'({1'b0, exp_fault(1'b0, ctrl[4])}));
        chk(16'(core_reset_o), 16'h0);
        for (int k = 0; k < 6; k++)
        begin
            at_speed_i <= 1'($urandom);
            wait_n(3);
            chk(16'(relay_o), 16'(at_speed_i));
        end
        for (int k = 0; k < 4; k++)
        begin
            {sig_a_i, sig_b_i, sig_c_i, sig_d_i} <= 48'({$urandom, $urandom});
            set_ctrl((ctrl & 12'h0bf) | {2'(3 - k), 2'(k), 8'h0});
            chk(16'(mon0_o), 16'(pick(2'(k))));
            chk(16'(mon1_o), 16'(pick(2'(3 - k))));
            rd(SDIO_MON1_ADDR, r);
            chk(r, 16'(pick(2'(3 - k))));
        end
        e = pick(2'd3);
        set_ctrl(ctrl | 12'h040);
        {sig_a_i, sig_b_i, sig_c_i, sig_d_i} <= 48'({$urandom, $urandom});
        wait_n(20);
        chk(16'(mon0_o), 16'(e));
        set_ctrl(ctrl & ~12'h040);
        chk(16'(mon0_o), 16'(pick(2'd3)));
        summarize();
    end
endmodule
